//--- logic/sequencer_pkg.sv
`default_nettype none
package sequencer_pkg;

  // address and word geometry
  localparam int ADDR_W   = 14;
  localparam int WORD_W   = 16;
  localparam int CODE_W   = 3;
  localparam int LIT_W    = 8;
  localparam int SAR_W    = 4;
  localparam int NANO_W   = 11;

  // field positions inside a microword; word bit 1 is index 15
  localparam int CTL_MSB  = 15;
  localparam int FIELD_LSB = 0;
  localparam int LIT_LSB  = 0;
  localparam int SAR_LSB  = 8;
  localparam int NANO_LSB = 0;

  // leading control bit codes
  localparam logic [1:0] LEAD_ALT     = 2'h0;
  localparam logic [1:0] LEAD_JUMP    = 2'h1;
  localparam logic [1:0] LEAD_CALL    = 2'h2;
  localparam logic [3:0] LEAD_SAR_LIT = 4'hC;
  localparam logic [3:0] LEAD_SAR     = 4'hD;
  localparam logic [3:0] LEAD_LIT     = 4'hE;

  // counter constants and reset values
  localparam logic [ADDR_W-1:0] ADDR_ONE   = 14'h0001;
  localparam logic [ADDR_W-1:0] ADDR_TWO   = 14'h0002;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 14'h0000;
  localparam logic [LIT_W-1:0]  LIT_RESET  = 8'h00;
  localparam logic [SAR_W-1:0]  SAR_RESET  = 4'h0;

  typedef enum logic [CODE_W-1:0] {
    SUCC_WAIT = 3'h0,
    SUCC_STEP = 3'h1,
    SUCC_SAVE = 3'h2,
    SUCC_SKIP = 3'h3,
    SUCC_EXECUTE_ONCE = 3'h4,
    SUCC_JUMP = 3'h5,
    SUCC_CALL = 3'h6,
    SUCC_RETURN_SUCCESSOR = 3'h7
  } succ_e;

  typedef enum logic [2:0] {
    FP_ARMED  = 3'h1,
    FP_FIRING = 3'h2,
    FP_SPENT  = 3'h4
  } force_e;

endpackage
`default_nettype wire

//--- logic/microprogram_address_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
module microprogram_address_sequencer
  import sequencer_pkg::*;
(
  input  wire logic                               clock_i,                    // 40 MHz clock
  input  wire logic                               rst_i,                      // sync reset
  input  wire logic [sequencer_pkg::WORD_W-1:0]   microprogram_store_i,       // current microword
  input  wire logic [sequencer_pkg::CODE_W-1:0]   true_successor_code_i,      // nanobits 11..13
  input  wire logic [sequencer_pkg::CODE_W-1:0]   false_successor_code_i,     // nanobits 14..16
  input  wire logic                               successor_condition_i,      // condition result
  input  wire logic                               phase_three_qualifier_bit_i, // phase 3 modifier
  input  wire logic                               phase_one_i,                // start of phase 1
  input  wire logic                               update_i,                   // end of microinstr
  input  wire logic                               hold_input_i,               // freeze sequencing
  input  wire logic                               sequential_mode_n_i,        // low: step all
  input  wire logic                               forced_long_format_i,       // force long format
  input  wire logic                               force_pulse_trigger_n_i,    // falling: fire
  input  wire logic                               force_rearm_n_i,            // falling: rearm
  output logic      [sequencer_pkg::ADDR_W-1:0]   micro_program_counter_o,    // counter
  output logic      [sequencer_pkg::ADDR_W-1:0]   alternate_counter_o,        // alternate
  output logic      [sequencer_pkg::ADDR_W-1:0]   incrementer_register_o,     // fetch address
  output logic      [sequencer_pkg::LIT_W-1:0]    literal_register_o,         // literal
  output logic      [sequencer_pkg::SAR_W-1:0]    shift_amount_register_o,    // shift amount
  output logic      [sequencer_pkg::NANO_W-1:0]   nano_address_o,             // short-format addr
  output logic                                    long_format_flag_o,         // long format
  output logic                                    branch_or_call_select_o,    // field to incrementer_register
  output logic                                    direct_call_flag_o,         // counter to alt
  output logic                                    phase_three_clock_inhibit_o, // inhibit phase 3
  output logic                                    phase_three_enable_o,       // do phase 3 ops
  output logic                                    force_step_o                // force pulse live
);
  import sequencer_pkg::*;

  logic [ADDR_W-1:0] mpc_q;
  logic [ADDR_W-1:0] mpc_d;
  logic [ADDR_W-1:0] alt_q;
  logic [ADDR_W-1:0] alt_d;
  logic [ADDR_W-1:0] incrementer_register_q;
  logic [ADDR_W-1:0] incrementer_register_d;
  logic [LIT_W-1:0]  lit_q;
  logic [SAR_W-1:0]  sar_q;
  logic [NANO_W-1:0] nano_q;
  succ_e             code_q;
  force_e            fp_q;
  logic              trig_prev_q;
  logic              rearm_prev_q;

  logic [3:0]        lead4;
  logic [1:0]        lead2;
  logic [ADDR_W-1:0] field;
  logic              forced;
  logic              long_format;
  logic              word_long;
  logic              alt_load;
  logic              bor_call;
  logic              direct_call_flag;
  logic              sar_load;
  logic              lit_load;
  logic              fire;
  logic              trig_fall;
  logic              rearm_fall;

  assign lead4 = microprogram_store_i[CTL_MSB -: 4];
  assign lead2 = microprogram_store_i[CTL_MSB -: 2];
  assign field = microprogram_store_i[FIELD_LSB +: ADDR_W];

  // hold blocks the whole update so a held CALL or SAVE cannot save twice
  assign fire = update_i & ~hold_input_i;

  // forcing decodes every word as a plain step: no jump, call or field load
  assign forced      = ~sequential_mode_n_i | forced_long_format_i | (fp_q == FP_FIRING);
  // only an all-ones lead marks a short word; any zero makes it long format
  assign word_long   = ~&lead4;
  assign long_format = word_long | forced;
  assign alt_load    = (lead2 == LEAD_ALT) & ~forced;
  assign direct_call_flag       = (lead2 == LEAD_CALL) & ~forced;
  assign bor_call    = direct_call_flag | ((lead2 == LEAD_JUMP) & ~forced);
  assign sar_load    = ((lead4 == LEAD_SAR_LIT) | (lead4 == LEAD_SAR)) & ~forced;
  assign lit_load    = ((lead4 == LEAD_SAR_LIT) | (lead4 == LEAD_LIT)) & ~forced;

  assign long_format_flag_o          = long_format;
  assign branch_or_call_select_o     = bor_call;
  assign direct_call_flag_o          = direct_call_flag;
  assign phase_three_clock_inhibit_o = long_format |
                                       (~successor_condition_i & phase_three_qualifier_bit_i);
  assign phase_three_enable_o        = ~phase_three_qualifier_bit_i | successor_condition_i;
  assign force_step_o                = (fp_q == FP_FIRING);

  assign micro_program_counter_o = mpc_q;
  assign alternate_counter_o     = alt_q;
  assign incrementer_register_o  = incrementer_register_q;
  assign literal_register_o      = lit_q;
  assign shift_amount_register_o = sar_q;
  assign nano_address_o          = nano_q;

  // successor code is chosen once per microinstruction
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      code_q <= SUCC_STEP;
    end else if (phase_one_i) begin
      code_q <= succ_e'(successor_condition_i ? true_successor_code_i
                                              : false_successor_code_i);
    end
  end

  // all sums stay at address width, so plus one or two wraps
  always_comb begin
    mpc_d  = mpc_q;
    alt_d  = alt_q;
    incrementer_register_d = incrementer_register_q;
    if (long_format) begin
      if (bor_call) begin
        mpc_d  = field + ADDR_ONE;
        incrementer_register_d = field + ADDR_ONE;
      end else begin
        mpc_d  = mpc_q + ADDR_ONE;
        incrementer_register_d = mpc_q + ADDR_ONE;
      end
      if (direct_call_flag) begin
        alt_d = mpc_q;
      end else if (alt_load) begin
        alt_d = field;
      end
    end else begin
      unique case (code_q)
        SUCC_WAIT: begin
          mpc_d = mpc_q;
        end
        SUCC_STEP: begin
          mpc_d  = mpc_q + ADDR_ONE;
          incrementer_register_d = mpc_q + ADDR_ONE;
        end
        SUCC_SAVE: begin
          mpc_d  = mpc_q + ADDR_ONE;
          incrementer_register_d = mpc_q + ADDR_ONE;
          alt_d  = mpc_q;
        end
        SUCC_SKIP: begin
          mpc_d  = mpc_q + ADDR_TWO;
          incrementer_register_d = mpc_q + ADDR_TWO;
        end
        SUCC_EXECUTE_ONCE: begin
          incrementer_register_d = alt_q + ADDR_ONE;
        end
        SUCC_JUMP: begin
          mpc_d  = alt_q + ADDR_ONE;
          incrementer_register_d = alt_q + ADDR_ONE;
        end
        SUCC_CALL: begin
          mpc_d  = alt_q + ADDR_ONE;
          incrementer_register_d = alt_q + ADDR_ONE;
          alt_d  = mpc_q;
        end
        SUCC_RETURN_SUCCESSOR: begin
          mpc_d  = alt_q + ADDR_TWO;
          incrementer_register_d = alt_q + ADDR_TWO;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      mpc_q  <= ADDR_RESET;
      alt_q  <= ADDR_RESET;
      incrementer_register_q <= ADDR_RESET;
    end else if (fire) begin
      mpc_q  <= mpc_d;
      alt_q  <= alt_d;
      incrementer_register_q <= incrementer_register_d;
    end
  end

  // field destinations; nano address ignores word bit five
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      lit_q  <= LIT_RESET;
      sar_q  <= SAR_RESET;
      nano_q <= '0;
    end else if (fire) begin
      if (lit_load) begin
        lit_q <= microprogram_store_i[LIT_LSB +: LIT_W];
      end
      if (sar_load) begin
        sar_q <= microprogram_store_i[SAR_LSB +: SAR_W];
      end
      if (!long_format) begin
        nano_q <= microprogram_store_i[NANO_LSB +: NANO_W];
      end
    end
  end

  // single-shot force step: armed, firing for one executed word, then spent
  assign trig_fall  = trig_prev_q & ~force_pulse_trigger_n_i;
  assign rearm_fall = rearm_prev_q & ~force_rearm_n_i;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      trig_prev_q  <= 1'b1;
      rearm_prev_q <= 1'b1;
    end else begin
      trig_prev_q  <= force_pulse_trigger_n_i;
      rearm_prev_q <= force_rearm_n_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      fp_q <= FP_ARMED;
    end else begin
      unique case (fp_q)
        FP_ARMED: begin
          if (trig_fall) begin
            fp_q <= FP_FIRING;
          end
        end
        FP_FIRING: begin
          if (fire) begin
            fp_q <= FP_SPENT;
          end
        end
        FP_SPENT: begin
          if (rearm_fall) begin
            fp_q <= FP_ARMED;
          end
        end
        default: begin
          fp_q <= FP_ARMED;
        end
      endcase
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  phase_three_gate_a: assert property (
    !phase_three_qualifier_bit_i |-> phase_three_enable_o &&
      (phase_three_clock_inhibit_o == long_format_flag_o))
    else $error("phase three not enabled with qualifier clear");

  wait_holds_a: assert property (
    fire && !long_format && code_q == SUCC_WAIT
    |=> $stable(mpc_q) && $stable(alt_q) && $stable(incrementer_register_q))
    else $error("wait changed a counter");

  step_adds_one_a: assert property (
    fire && !long_format && code_q == SUCC_STEP
    |=> mpc_q == $past(mpc_q) + ADDR_ONE && incrementer_register_q == mpc_q && $stable(alt_q))
    else $error("step did not add one");

  save_copies_a: assert property (
    fire && !long_format && code_q == SUCC_SAVE
    |=> alt_q == $past(mpc_q) && incrementer_register_q == $past(mpc_q) + ADDR_ONE)
    else $error("save did not copy counter");

  skip_adds_two_a: assert property (
    fire && !long_format && code_q == SUCC_SKIP
    |=> mpc_q == $past(mpc_q) + ADDR_TWO && incrementer_register_q == mpc_q)
    else $error("skip did not add two");

  jump_from_alt_a: assert property (
    fire && !long_format && code_q == SUCC_JUMP
    |=> mpc_q == $past(alt_q) + ADDR_ONE && $stable(alt_q))
    else $error("jump target wrong");

  execute_once_once_a: assert property (
    fire && !long_format && code_q == SUCC_EXECUTE_ONCE
    |=> incrementer_register_q == $past(alt_q) + ADDR_ONE && $stable(mpc_q) && $stable(alt_q))
    else $error("execute once altered counters");

  call_swap_a: assert property (
    fire && !long_format && code_q == SUCC_CALL
    |=> mpc_q == $past(alt_q) + ADDR_ONE && alt_q == $past(mpc_q))
    else $error("call did not swap");

  return_adds_two_a: assert property (
    fire && !long_format && code_q == SUCC_RETURN_SUCCESSOR
    |=> mpc_q == $past(alt_q) + ADDR_TWO && incrementer_register_q == mpc_q)
    else $error("return target wrong");

  long_call_a: assert property (
    fire && direct_call_flag |=> mpc_q == $past(field) + ADDR_ONE && alt_q == $past(mpc_q))
    else $error("long call wrong");

  long_jump_a: assert property (
    fire && bor_call && !direct_call_flag |=> mpc_q == $past(field) + ADDR_ONE && $stable(alt_q))
    else $error("long jump wrong");

  code_latch_a: assert property (
    phase_one_i |=> code_q == ($past(successor_condition_i) ? $past(true_successor_code_i)
                                                           : $past(false_successor_code_i)))
    else $error("wrong successor code latched");

  sequential_step_a: assert property (
    update_i && !hold_input_i && !sequential_mode_n_i
    |-> long_format_flag_o && !branch_or_call_select_o
    ##1 (mpc_q == $past(mpc_q) + ADDR_ONE && incrementer_register_q == mpc_q))
    else $error("sequential mode did not step");

  force_one_shot_a: assert property (
    fp_q == FP_ARMED && trig_fall |=> force_step_o && long_format_flag_o &&
      !branch_or_call_select_o)
    else $error("force trigger gave no pulse");

  force_consumed_a: assert property (
    force_step_o && fire |=> !force_step_o ##1 !force_step_o)
    else $error("force pulse repeated");

  inhibit_long_a: assert property (
    long_format_flag_o |-> phase_three_clock_inhibit_o)
    else $error("inhibit missing on long format");

  hold_freezes_a: assert property (
    update_i && hold_input_i |=> $stable(mpc_q) && $stable(incrementer_register_q))
    else $error("hold did not freeze");

endmodule
`default_nettype wire

//--- verif/nano_phase_model.sv
`timescale 1ns/10ps
`default_nettype none
// stands in for the nanoinstruction control: one phase one pulse when with_p1_i is high, then one update pulse
module nano_phase_model (
  input  wire logic clock_i,    // system clock
  input  wire logic rst_i,      // sync reset
  input  wire logic start_i,    // begin one microinstruction
  input  wire logic with_p1_i,  // low: skip phase one, reuse the latched code
  output logic      phase_one_o, // latch successor code
  output logic      update_o,    // end of microinstruction
  output logic      done_o       // counters have been applied
);
  // pulses are one cycle wide so the sequencer never sees a doubled update
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      phase_one_o <= 1'b0;
      update_o    <= 1'b0;
      done_o      <= 1'b0;
    end else begin
      phase_one_o <= start_i && with_p1_i;
      update_o    <= (start_i && !with_p1_i) || phase_one_o;
      done_o      <= update_o;
    end
  end
endmodule
`default_nettype wire

//--- verif/microprogram_address_sequencer_test.sv
`timescale 1ns/10ps
`default_nettype none
module microprogram_address_sequencer_test;
  import sequencer_pkg::*;
  logic              clock = 1'b0;
  logic              rst = 1'b1;
  logic [WORD_W-1:0] word = 16'hF000;
  logic [CODE_W-1:0] tcode = 3'h1;
  logic [CODE_W-1:0] fcode = 3'h1;
  logic              cond = 1'b1;
  logic              qual = 1'b0;
  logic              hold = 1'b0;
  logic              seq_n = 1'b1;
  logic              forced = 1'b0;
  logic              trig_n = 1'b1;
  logic              rearm_n = 1'b1;
  logic              start = 1'b0;
  logic              with_p1 = 1'b1;
  logic [ADDR_W-1:0] mpc, alt, incrementer_register;
  logic [LIT_W-1:0]  literal_register;
  logic [SAR_W-1:0]  shift_amount_register;
  logic [NANO_W-1:0] nano;
  logic              lf, boc, dc, inh, p3, fs, p1, upd, done;
  logic [ADDR_W-1:0] em = 14'h0000;
  logic [ADDR_W-1:0] ea = 14'h0000;
  logic [ADDR_W-1:0] ei = 14'h0000;
  int                errors = 0;
  int                checked = 0;

  always #12.5 clock = ~clock;

  nano_phase_model model_u (.clock_i(clock), .rst_i(rst), .start_i(start),
    .with_p1_i(with_p1), .phase_one_o(p1), .update_o(upd), .done_o(done));

  microprogram_address_sequencer dut_u (.clock_i(clock), .rst_i(rst),
    .microprogram_store_i(word), .true_successor_code_i(tcode),
    .false_successor_code_i(fcode), .successor_condition_i(cond),
    .phase_three_qualifier_bit_i(qual), .phase_one_i(p1), .update_i(upd),
    .hold_input_i(hold), .sequential_mode_n_i(seq_n), .forced_long_format_i(forced),
    .force_pulse_trigger_n_i(trig_n), .force_rearm_n_i(rearm_n),
    .micro_program_counter_o(mpc), .alternate_counter_o(alt),
    .incrementer_register_o(incrementer_register), .literal_register_o(literal_register),
    .shift_amount_register_o(shift_amount_register), .nano_address_o(nano), .long_format_flag_o(lf),
    .branch_or_call_select_o(boc), .direct_call_flag_o(dc),
    .phase_three_clock_inhibit_o(inh), .phase_three_enable_o(p3), .force_step_o(fs));

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic chk3();
    chk("counter", 16'(mpc), 16'(em));
    chk("alternate", 16'(alt), 16'(ea));
    chk("incrementer", 16'(incrementer_register), 16'(ei));
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // inputs stay put from start until the update edge has landed
  task automatic run(input logic [15:0] w, input logic with_p);
    int k;
    word = w;
    with_p1 = with_p;
    start = 1'b1;
    tick(1);
    start = 1'b0;
    for (k = 0; k < 20 && done !== 1'b1; k++) tick(1);
    // a model that never finishes counts against the run
    chk("done", 16'(done), 16'h0001);
  endtask

  task automatic adv();
    em = em + ADDR_ONE;
    ei = em;
  endtask

  task automatic t_reset();
    chk3();
    run(16'hF001, 1'b0);
    adv();
    chk3();
    chk("long flag", 16'(lf), 16'h0000);
  endtask

  task automatic t_alt();
    run(16'h0ABC, 1'b1);
    ea = 14'h0ABC;
    adv();
    chk3();
    chk("long flag", 16'(lf), 16'h0001);
    chk("inhibit", 16'(inh), 16'h0001);
  endtask

  task automatic t_succ();
    logic [ADDR_W-1:0] nm;
    logic [2:0]        c;
    for (int k = 0; k < 8; k++) begin
      c = k[2:0];
      cond = c[0];
      qual = c[1];
      tcode = cond ? c : ~c;
      fcode = cond ? ~c : c;
      run(16'hF800 + 16'(c) * 16'h0093, 1'b1);
      case (c)
        3'h1, 3'h2: nm = em + ADDR_ONE;
        3'h3: nm = em + ADDR_TWO;
        3'h5, 3'h6: nm = ea + ADDR_ONE;
        3'h7: nm = ea + ADDR_TWO;
        default: nm = em;
      endcase
      ei = (c == 3'h4) ? ea + ADDR_ONE : ((c == 3'h0) ? ei : nm);
      if (c == 3'h2 || c == 3'h6) ea = em;
      em = nm;
      chk3();
      chk("nano", 16'(nano), 16'(c) * 16'h0093);
      chk("phase three", 16'(p3), 16'(!qual || cond));
      chk("inhibit", 16'(inh), 16'(!cond && qual));
    end
  endtask

  task automatic t_long();
    run(16'h4123, 1'b1);
    em = 14'h0124;
    ei = em;
    chk3();
    chk("select", 16'({boc, dc}), 16'h0002);
    run(16'h8200, 1'b1);
    ea = em;
    em = 14'h0201;
    ei = em;
    chk3();
    chk("select", 16'({boc, dc}), 16'h0003);
    run(16'h7FFF, 1'b1);
    em = 14'h0000;
    ei = em;
    chk3();
  endtask

  task automatic t_litsar();
    run(16'hC5A7, 1'b1);
    adv();
    chk3();
    chk("fields", {literal_register, 4'h0, shift_amount_register}, 16'hA705);
    run(16'hD35C, 1'b1);
    adv();
    chk("fields", {literal_register, 4'h0, shift_amount_register}, 16'hA703);
    run(16'hE96B, 1'b1);
    adv();
    chk("fields", {literal_register, 4'h0, shift_amount_register}, 16'h6B03);
  endtask

  task automatic t_hold();
    hold = 1'b1;
    tcode = 3'h1;
    fcode = 3'h1;
    run(16'hF000, 1'b1);
    chk3();
    hold = 1'b0;
  endtask

  // forcing must turn an alternate-load word, or a jump, into a plain step
  task automatic t_modes();
    tcode = 3'h7;
    fcode = 3'h7;
    seq_n = 1'b0;
    run(16'h0555, 1'b1);
    adv();
    chk3();
    word = 16'hF000;
    tick(1);
    chk("long flag", 16'(lf), 16'h0001);
    seq_n = 1'b1;
    forced = 1'b1;
    run(16'h4321, 1'b1);
    adv();
    chk3();
    forced = 1'b0;
  endtask

  task automatic t_force();
    word = 16'hF000;
    trig_n = 1'b0;
    tick(2);
    chk("force", 16'({fs, lf}), 16'h0003);
    run(16'hF000, 1'b1);
    adv();
    chk3();
    chk("force", 16'(fs), 16'h0000);
    trig_n = 1'b1;
    tick(2);
    trig_n = 1'b0;
    tick(2);
    chk("force", 16'(fs), 16'h0000);
    rearm_n = 1'b0;
    tick(2);
    rearm_n = 1'b1;
    trig_n = 1'b1;
    tick(2);
    trig_n = 1'b0;
    tick(2);
    chk("force", 16'(fs), 16'h0001);
    run(16'hF000, 1'b1);
    adv();
    chk3();
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    tick(5);
    rst = 1'b0;
    tick(1);
    t_reset();
    t_alt();
    t_succ();
    t_long();
    t_litsar();
    t_hold();
    t_modes();
    t_force();
    stop_test();
  end

  // the whole sequence needs fewer than a hundred cycles
  initial begin
    repeat (3000) @(posedge clock);
    errors++;
    stop_test();
  end
endmodule
`default_nettype wire
